/* hdl/ppc_consts.vh */
// constants for the plug detect and power control block
// assumes inclusion by ppc_top.v only
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH

// ****************************************
// register offsets on the management link
// ****************************************
`define PPC_REG_CTL       5'h00
`define PPC_REG_PSC       5'h10

// ****************************************
// control register fields
// ****************************************
`define PPC_CTL_SRST      15
`define PPC_CTL_LOOP      14
`define PPC_CTL_SPEED     13
`define PPC_CTL_ANEN      12
`define PPC_CTL_PDOWN     11
`define PPC_CTL_ISO       10
`define PPC_CTL_ANRST     9
`define PPC_CTL_DUPLEX    8
`define PPC_CTL_LOW_RST   8'h80
`define PPC_CTL_SPEED_RST 1'b1
`define PPC_CTL_ANEN_RST  1'b1

// ****************************************
// power status and control register fields
// ****************************************
`define PPC_PSC_AUTODIS   13
`define PPC_PSC_PD_FAST   10
`define PPC_PSC_PD_SLOW   9
`define PPC_PSC_AUTO_RST  1'b1

// ****************************************
// management frame codes
// ****************************************
`define PPC_OP_RD         2'b10
`define PPC_OP_WR         2'b01
`define PPC_PHY_ADDR      5'h01

// ****************************************
// timing
// ****************************************
`define PPC_CLK_MHZ       250
`define PPC_QUIET_MS      6600
`define PPC_QUIET_CYC     (32'd6600 * 32'd250000)
`define PPC_DEAD_NS       560
`define PPC_DEAD_CYC      ((`PPC_DEAD_NS * `PPC_CLK_MHZ + 999) / 1000)
`define PPC_SRST_CYC      8'h10

`endif

/* hdl/ppc_top.v */
// plug detect, reduced power and low control bits of a 10/100 phy
// assumes a management clock and data pin from the mac, an energy
// detector on the line, and negotiation results on core_clk
//
// Behaviour
// - quiet line longer than 6.6 s clears the plugged flag
// - in reduced power, energy sets the plugged flag well under 1 s
// - activity means line energy only, not frames or pulses
// - automatic mode enters reduced power when unplugged
// - automatic mode leaves only with request clear and plugged
// - manual mode: reduced power exactly while power-down requested
// - reduced power switches line circuits off, detector stays on
// - management link and all registers stay usable in reduced power
// - reduced power forces the host link to 10 Mbps, 5 MHz
// - bit 13 of register 16 disables automatic mode, default 1
// - bits 10 and 9 of register 16 read 1 in reduced power
// - control bit 11 ORed with host power-down pin requests it
// - control bit 15 resets registers, reads 1 until done
// - bit 14 loops transmit to receive, 560 ns dead time
// - config loopback bit wins over media loopback
// - bit 13 selects speed when negotiation off, default 1
// - bit 12 enables negotiation, default 1, masks bits 13, 8
// - registers reached only by management frames
// - bit 10 isolates the internal media interface, default 0
// - bit 9 restarts negotiation and clears itself
`timescale 1ns/1ns
`include "ppc_consts.vh"

module ppc_top #(
  parameter [31:0] QUIET_CYC = `PPC_QUIET_CYC,
  parameter [7:0]  SRST_CYC  = `PPC_SRST_CYC,
  parameter [4:0]  PHY_ADDR  = `PPC_PHY_ADDR
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // management link
  input  wire        mgmt_clk,
  input  wire        mgmt_data_i,
  output wire        mgmt_data_o,
  output wire        mgmt_data_oe,
  // line and host inputs
  input  wire        line_energy,
  input  wire        host_pdown,
  input  wire        loopback_mdi,
  input  wire        an_speed_100,
  input  wire        an_full_duplex,
  // status and control outputs
  output wire        plugged_state_flag,
  output wire        reduced_power,
  output wire        line_off,
  output wire        host_link_slow,
  output wire        loopback_en,
  output wire        loopback_from_cfg,
  output wire        rx_dead,
  output wire        mii_isolate,
  output wire        an_enable,
  output wire        an_restart,
  output wire        speed_100,
  output wire        full_duplex
);

  localparam [31:0] DEAD_FULL = `PPC_DEAD_CYC;
  localparam [7:0]  DEAD_CYC  = DEAD_FULL[7:0];

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ST2  = 3'h1;
  localparam [2:0] ST_HDR  = 3'h2;
  localparam [2:0] ST_TA   = 3'h3;
  localparam [2:0] ST_RDAT = 3'h4;
  localparam [2:0] ST_WDAT = 3'h5;

  // stable level once second and third stage agree
  function stable;
    input s2;
    input s3;
    input lvl;
    begin
      stable = (s2 == s3) ? s3 : lvl;
    end
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [2:0]  mclk_s_r;
  reg [2:0]  mdat_s_r;
  reg [2:0]  eng_s_r;
  reg        mclk_lvl_r;
  reg        mdat_lvl_r;
  reg        eng_lvl_r;
  wire       mclk_nxt;
  wire       mclk_rise;

  assign mclk_nxt  = stable(mclk_s_r[1], mclk_s_r[2], mclk_lvl_r);
  assign mclk_rise = mclk_nxt & ~mclk_lvl_r;

  // three stage capture of pin inputs
  always @(posedge core_clk) begin
    if (reset) begin
      mclk_s_r   <= 3'h0;
      mdat_s_r   <= 3'h7;
      eng_s_r    <= 3'h0;
      mclk_lvl_r <= 1'b0;
      mdat_lvl_r <= 1'b1;
      eng_lvl_r  <= 1'b0;
    end else begin
      mclk_s_r   <= {mclk_s_r[1:0], mgmt_clk};
      mdat_s_r   <= {mdat_s_r[1:0], mgmt_data_i};
      eng_s_r    <= {eng_s_r[1:0], line_energy};
      mclk_lvl_r <= mclk_nxt;
      mdat_lvl_r <= stable(mdat_s_r[1], mdat_s_r[2], mdat_lvl_r);
      eng_lvl_r  <= stable(eng_s_r[1], eng_s_r[2], eng_lvl_r);
    end
  end

  // ****************************************
  // register state
  // ****************************************
  reg        loop_r;
  reg        speed_r;
  reg        anen_r;
  reg        pdown_r;
  reg        iso_r;
  reg        dup_r;
  reg [7:0]  low_r;
  reg        autodis_r;
  reg [7:0]  srst_cnt_r;
  reg        anrst_r;
  reg        rp_r;
  reg        plug_r;
  reg [31:0] quiet_r;
  reg        loop_d_r;
  reg [7:0]  dead_r;
  reg        dead_o_r;
  reg        lb_en_r;
  reg        spd_eff_r;
  reg        dup_eff_r;

  // ****************************************
  // management frame engine
  // ****************************************
  reg [2:0]  st_r;
  reg [3:0]  cnt_r;
  reg [11:0] hdr_r;
  reg [15:0] sh_r;
  reg        prev_r;
  reg        mdo_r;
  reg        mdoe_r;
  reg        wr_r;
  reg [15:0] wdat_r;
  reg [4:0]  wreg_r;
  reg [15:0] rdata;
  wire       hit;
  wire       is_rd;
  wire [11:0] hdr_nxt;

  assign hdr_nxt = {hdr_r[10:0], mdat_lvl_r};
  assign hit     = (hdr_r[9:5] == PHY_ADDR);
  assign is_rd   = (hdr_r[11:10] == `PPC_OP_RD);

  // read value of the addressed register
  always @* begin
    rdata = 16'h0000;
    if (hdr_r[4:0] == `PPC_REG_CTL) begin
      rdata[`PPC_CTL_SRST]   = (srst_cnt_r != 8'h00);
      rdata[`PPC_CTL_LOOP]   = loop_r;
      rdata[`PPC_CTL_SPEED]  = speed_r;
      rdata[`PPC_CTL_ANEN]   = anen_r;
      rdata[`PPC_CTL_PDOWN]  = pdown_r;
      rdata[`PPC_CTL_ISO]    = iso_r;
      rdata[`PPC_CTL_DUPLEX] = anen_r | dup_r;
      rdata[7:0]             = low_r;
    end else if (hdr_r[4:0] == `PPC_REG_PSC) begin
      rdata[`PPC_PSC_AUTODIS] = autodis_r;
      rdata[`PPC_PSC_PD_FAST] = rp_r;
      rdata[`PPC_PSC_PD_SLOW] = rp_r;
    end
  end

  // frame decode on each management clock rise
  always @(posedge core_clk) begin
    if (reset) begin
      st_r   <= ST_IDLE;
      cnt_r  <= 4'h0;
      hdr_r  <= 12'h000;
      sh_r   <= 16'h0000;
      prev_r <= 1'b0;
      mdo_r  <= 1'b0;
      mdoe_r <= 1'b0;
      wr_r   <= 1'b0;
      wdat_r <= 16'h0000;
      wreg_r <= 5'h00;
    end else begin
      wr_r <= 1'b0;
      if (mclk_rise) begin
        prev_r <= mdat_lvl_r;
        case (st_r)
          ST_IDLE: begin
            if (prev_r && !mdat_lvl_r)
              st_r <= ST_ST2;
          end
          ST_ST2: begin
            cnt_r <= 4'h0;
            st_r  <= mdat_lvl_r ? ST_HDR : ST_IDLE;
          end
          ST_HDR: begin
            hdr_r <= hdr_nxt;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'hb) begin
              cnt_r <= 4'h0;
              st_r  <= ST_TA;
            end
          end
          ST_TA: begin
            if (cnt_r == 4'h0) begin
              cnt_r <= 4'h1;
              if (is_rd && hit) begin
                mdoe_r <= 1'b1;
                mdo_r  <= 1'b0;
              end
            end else begin
              cnt_r <= 4'h0;
              sh_r  <= rdata;
              mdo_r <= rdata[15];
              st_r  <= is_rd ? ST_RDAT : ST_WDAT;
            end
          end
          ST_RDAT: begin
            if (cnt_r == 4'hf) begin
              mdoe_r <= 1'b0;
              mdo_r  <= 1'b0;
              st_r   <= ST_IDLE;
            end else begin
              sh_r  <= {sh_r[14:0], 1'b0};
              mdo_r <= sh_r[14];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          ST_WDAT: begin
            sh_r  <= {sh_r[14:0], mdat_lvl_r};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'hf) begin
              st_r   <= ST_IDLE;
              wr_r   <= hit && (hdr_r[11:10] == `PPC_OP_WR);
              wdat_r <= {sh_r[14:0], mdat_lvl_r};
              wreg_r <= hdr_r[4:0];
            end
          end
          default: begin
            st_r   <= ST_IDLE;
            mdoe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // control registers and soft reset
  // ****************************************
  always @(posedge core_clk) begin
    if (reset || srst_cnt_r != 8'h00) begin
      // defaults under hard reset and while soft reset runs
      loop_r     <= 1'b0;
      speed_r    <= `PPC_CTL_SPEED_RST;
      anen_r     <= `PPC_CTL_ANEN_RST;
      pdown_r    <= 1'b0;
      iso_r      <= 1'b0;
      dup_r      <= 1'b0;
      low_r      <= `PPC_CTL_LOW_RST;
      autodis_r  <= `PPC_PSC_AUTO_RST;
      anrst_r    <= 1'b0;
      srst_cnt_r <= reset ? 8'h00 : srst_cnt_r - 8'h01;
    end else begin
      anrst_r <= 1'b0;
      if (wr_r && wreg_r == `PPC_REG_CTL) begin
        if (wdat_r[`PPC_CTL_SRST]) begin
          srst_cnt_r <= SRST_CYC;
        end else begin
          loop_r  <= wdat_r[`PPC_CTL_LOOP];
          speed_r <= wdat_r[`PPC_CTL_SPEED];
          anen_r  <= wdat_r[`PPC_CTL_ANEN];
          pdown_r <= wdat_r[`PPC_CTL_PDOWN];
          iso_r   <= wdat_r[`PPC_CTL_ISO];
          anrst_r <= wdat_r[`PPC_CTL_ANRST];
          low_r   <= wdat_r[7:0];
          if (!anen_r)
            dup_r <= wdat_r[`PPC_CTL_DUPLEX];
        end
      end
      if (wr_r && wreg_r == `PPC_REG_PSC)
        autodis_r <= wdat_r[`PPC_PSC_AUTODIS];
    end
  end

  // ****************************************
  // plug detection and power state
  // ****************************************
  wire pd_req;

  assign pd_req = pdown_r | host_pdown;

  always @(posedge core_clk) begin
    if (reset) begin
      quiet_r <= 32'h0000_0000;
      plug_r  <= 1'b1;
      rp_r    <= 1'b0;
    end else begin
      // quiet timer restarts on energy
      if (eng_lvl_r) begin
        quiet_r <= 32'h0000_0000;
        plug_r  <= 1'b1;
      end else if (quiet_r < QUIET_CYC) begin
        quiet_r <= quiet_r + 32'h0000_0001;
      end else begin
        plug_r <= 1'b0;
      end
      // power state selection
      if (autodis_r)
        rp_r <= pd_req;
      else if (pd_req || !plug_r)
        rp_r <= 1'b1;
      else
        rp_r <= 1'b0;
    end
  end

  // ****************************************
  // loopback and effective speed
  // ****************************************
  always @(posedge core_clk) begin
    if (reset) begin
      loop_d_r  <= 1'b0;
      dead_r    <= 8'h00;
      dead_o_r  <= 1'b0;
      lb_en_r   <= 1'b0;
      spd_eff_r <= 1'b0;
      dup_eff_r <= 1'b0;
    end else begin
      loop_d_r <= loop_r;
      lb_en_r  <= loop_r | loopback_mdi;
      // dead time counter with a registered flag for the pin
      if (loop_r && !loop_d_r) begin
        dead_r   <= DEAD_CYC;
        dead_o_r <= 1'b1;
      end else if (dead_r != 8'h00) begin
        dead_r   <= dead_r - 8'h01;
        dead_o_r <= (dead_r != 8'h01);
      end
      if (rp_r)
        spd_eff_r <= 1'b0;
      else
        spd_eff_r <= anen_r ? an_speed_100 : speed_r;
      dup_eff_r <= anen_r ? an_full_duplex : dup_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign mgmt_data_o        = mdo_r;
  assign mgmt_data_oe       = mdoe_r;
  assign plugged_state_flag = plug_r;
  assign reduced_power      = rp_r;
  assign line_off           = rp_r;
  assign host_link_slow     = rp_r;
  assign loopback_en        = lb_en_r;
  assign loopback_from_cfg  = loop_d_r;
  assign rx_dead            = dead_o_r;
  assign mii_isolate        = iso_r;
  assign an_enable          = anen_r;
  assign an_restart         = anrst_r;
  assign speed_100          = spd_eff_r;
  assign full_duplex        = dup_eff_r;

endmodule

/* sim/ppc_props.sv */
// port checks for the plug detect and power control block
// assumes a bind onto ppc_top, one clock domain on core_clk
`timescale 1ns/1ns
module ppc_props #(
  parameter [31:0] QUIET_CYC = 32'h62590080
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // inputs watched
  input wire line_energy,
  input wire host_pdown,
  input wire loopback_mdi,
  input wire an_full_duplex,
  // outputs watched
  input wire mgmt_data_o,
  input wire mgmt_data_oe,
  input wire plugged_state_flag,
  input wire reduced_power,
  input wire line_off,
  input wire host_link_slow,
  input wire loopback_en,
  input wire rx_dead,
  input wire an_enable,
  input wire an_restart,
  input wire speed_100,
  input wire full_duplex
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [31:0] quiet_r;
  logic [7:0]  dead_r;
  // quiet run length and dead time length
  always @(posedge core_clk) begin
    if (reset || line_energy) quiet_r <= 32'h0;
    else if (quiet_r != 32'hffffffff) quiet_r <= quiet_r + 32'h1;
    dead_r <= (rx_dead && !reset) ? dead_r + 8'h1 : 8'h0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // assertions
  // ****************************************
  sequence s_energy; line_energy [*8]; endsequence
  sequence s_pd_held; host_pdown [*3]; endsequence
  sequence s_an_fd; (an_enable && an_full_duplex) [*3]; endsequence
  chk_quiet_early: assert property ($fell(plugged_state_flag) |-> quiet_r >= QUIET_CYC)
    else $error("plugged flag cleared early");
  chk_quiet_late: assert property (quiet_r > QUIET_CYC + 32'h8 |-> !plugged_state_flag)
    else $error("plugged flag not cleared");
  chk_plug_fast: assert property (s_energy |-> plugged_state_flag)
    else $error("plugged flag not set");
  chk_pd_enter: assert property (s_pd_held |-> reduced_power)
    else $error("power down ignored");
  chk_pd_leave: assert property ($fell(reduced_power) |-> !$past(host_pdown))
    else $error("left reduced power early");
  chk_line_off: assert property (line_off == reduced_power)
    else $error("line circuits wrong");
  chk_slow_link: assert property (host_link_slow == reduced_power)
    else $error("host link speed wrong");
  chk_speed_low: assert property (reduced_power [*2] |-> !speed_100)
    else $error("fast speed in reduced power");
  chk_restart_pulse: assert property (an_restart |=> !an_restart)
    else $error("restart not a pulse");
  chk_ta_zero: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_o)
    else $error("turnaround bit not zero");
  chk_dead_len: assert property ($fell(rx_dead) |-> dead_r == 8'h8c)
    else $error("dead time length wrong");
  chk_mdi_loop: assert property (loopback_mdi [*2] |-> loopback_en)
    else $error("media loopback ignored");
  chk_an_duplex: assert property (s_an_fd |-> full_duplex)
    else $error("duplex not negotiated");
endmodule

/* sim/ppc_mac_model.sv */
// management link master standing in for the mac
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ns
module ppc_mac_model (
  // clock
  input  wire  core_clk,
  // management link
  input  wire  mdio,
  output logic mgmt_clk,
  output logic mac_oe,
  output logic mac_o
);
  initial begin
    mgmt_clk = 1'b0;
    mac_oe   = 1'b0;
    mac_o    = 1'b1;
  end
  // preamble bit and frame, clock still between frames
  task automatic xfer(input logic rd, input logic [4:0] pa, ra, input logic [15:0] wd, output logic [15:0] q);
    logic [32:0] f;
    f = {3'b101, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
    q = 16'h0;
    for (int i = 0; i < 33; i++) begin
      @(posedge core_clk);
      mgmt_clk <= 1'b0;
      mac_oe   <= !(rd && i > 14);
      mac_o    <= f[32-i];
      repeat (4) @(posedge core_clk);
      mgmt_clk <= 1'b1;
      if (i > 16) q = {q[14:0], mdio};
      repeat (3) @(posedge core_clk);
    end
    @(posedge core_clk);
    mgmt_clk <= 1'b0;
    mac_oe   <= 1'b0;
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the plug detect and power control block
// assumes the mac model runs the management link at 32 ns a bit
`timescale 1ns/1ns
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        line_energy = 1'b1;
  logic        host_pdown = 1'b0;
  logic        loopback_mdi = 1'b0;
  logic        seen_rst = 1'b0;
  logic        w, sp, fd;
  logic [4:0]  pa, ra;
  logic [15:0] d, q;
  int          bad_count = 0;
  int          n_compared = 0;
  wire         mgmt_clk, mac_oe, mac_o, mdo, mdoe, plug, rp, loff, slow;
  wire         lben, lbcfg, dead, iso, anen, anrst, spd, fdx;
  wire         mdio = mdoe ? mdo : (mac_oe ? mac_o : 1'b1);
  localparam logic [28:0] ROWS [0:9] = '{
    {1'b0, 5'h01, 5'h00, 16'h3180, 2'b01}, {1'b0, 5'h01, 5'h10, 16'h2000, 2'b01},
    {1'b0, 5'h01, 5'h05, 16'h0000, 2'b01}, {1'b0, 5'h02, 5'h00, 16'hffff, 2'b01},
    {1'b1, 5'h02, 5'h00, 16'h0800, 2'b01}, {1'b0, 5'h01, 5'h00, 16'h3180, 2'b01},
    {1'b1, 5'h01, 5'h00, 16'h0055, 2'b00}, {1'b0, 5'h01, 5'h00, 16'h0055, 2'b00},
    {1'b1, 5'h01, 5'h00, 16'h2100, 2'b11}, {1'b0, 5'h01, 5'h00, 16'h2100, 2'b11}};
  ppc_top #(.QUIET_CYC(32'h000000c8), .SRST_CYC(8'hc8)) i_dut (
    .core_clk(core_clk), .reset(reset), .mgmt_clk(mgmt_clk), .mgmt_data_i(mdio),
    .mgmt_data_o(mdo), .mgmt_data_oe(mdoe), .line_energy(line_energy),
    .host_pdown(host_pdown), .loopback_mdi(loopback_mdi), .an_speed_100(1'b0),
    .an_full_duplex(1'b1), .plugged_state_flag(plug), .reduced_power(rp),
    .line_off(loff), .host_link_slow(slow), .loopback_en(lben),
    .loopback_from_cfg(lbcfg), .rx_dead(dead), .mii_isolate(iso),
    .an_enable(anen), .an_restart(anrst), .speed_100(spd), .full_duplex(fdx));
  ppc_mac_model i_mac (.core_clk(core_clk), .mdio(mdio), .mgmt_clk(mgmt_clk), .mac_oe(mac_oe), .mac_o(mac_o));
  // ****************************************
  // clock, catcher and tasks
  // ****************************************
  always #2 core_clk = ~core_clk;
  // remember any restart pulse
  always @(posedge core_clk) if (anrst) seen_rst <= 1'b1;
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] v);
    i_mac.xfer(1'b0, 5'h01, a, v, q);
    repeat (4) @(posedge core_clk);
  endtask
  task rdc(input logic [4:0] p, a, input logic [15:0] e);
    i_mac.xfer(1'b1, p, a, 16'h0, q);
    cmp(q, e);
  endtask
  task wait_plug(input logic v);
    int n;
    for (n = 0; n < 400 && plug !== v; n++) @(posedge core_clk);
    cmp({15'h0, plug}, {15'h0, v});
    if (n == 400) summarize;
  endtask
  // cut a hang short
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      {w, pa, ra, d, sp, fd} = ROWS[i];
      if (w) i_mac.xfer(1'b0, pa, ra, d, q);
      else rdc(pa, ra, d);
      repeat (4) @(posedge core_clk);
      cmp({14'h0, spd, fdx}, {14'h0, sp, fd});
    end
    $display("table done");
    host_pdown <= 1'b1;
    repeat (4) @(posedge core_clk);
    cmp({13'h0, rp, loff, slow}, 16'h0007);
    rdc(5'h01, 5'h10, 16'h2600);
    host_pdown <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmp({15'h0, rp}, 16'h0000);
    wr(5'h00, 16'h2900);
    cmp({15'h0, rp}, 16'h0001);
    wr(5'h00, 16'h2100);
    cmp({15'h0, rp}, 16'h0000);
    $display("manual power done");
    wr(5'h10, 16'h0000);
    line_energy <= 1'b0;
    repeat (150) @(posedge core_clk);
    line_energy <= 1'b1;
    repeat (8) @(posedge core_clk);
    line_energy <= 1'b0;
    repeat (150) @(posedge core_clk);
    cmp({15'h0, plug}, 16'h0001);
    wait_plug(1'b0);
    repeat (4) @(posedge core_clk);
    cmp({15'h0, rp}, 16'h0001);
    rdc(5'h01, 5'h10, 16'h0600);
    host_pdown <= 1'b1;
    line_energy <= 1'b1;
    wait_plug(1'b1);
    repeat (4) @(posedge core_clk);
    cmp({15'h0, rp}, 16'h0001);
    host_pdown <= 1'b0;
    repeat (4) @(posedge core_clk);
    cmp({15'h0, rp}, 16'h0000);
    wr(5'h10, 16'h2000);
    $display("auto power done");
    wr(5'h00, 16'h6100);
    cmp({13'h0, lben, lbcfg, dead}, 16'h0007);
    repeat (150) @(posedge core_clk);
    cmp({15'h0, dead}, 16'h0000);
    loopback_mdi <= 1'b1;
    wr(5'h00, 16'h2100);
    cmp({14'h0, lben, lbcfg}, 16'h0002);
    loopback_mdi <= 1'b0;
    wr(5'h00, 16'h3300);
    cmp({15'h0, seen_rst}, 16'h0001);
    rdc(5'h01, 5'h00, 16'h3100);
    wr(5'h00, 16'h2500);
    cmp({15'h0, iso}, 16'h0001);
    wr(5'h00, 16'h8000);
    repeat (20) @(posedge core_clk);
    rdc(5'h01, 5'h00, 16'hb180);
    rdc(5'h01, 5'h00, 16'h3180);
    cmp({15'h0, iso}, 16'h0000);
    $display("control bits done");
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp({13'h0, plug, rp, anen}, 16'h0005);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    rdc(5'h01, 5'h00, 16'h3180);
    $display("reset done");
    summarize;
  end
endmodule
bind ppc_top ppc_props #(.QUIET_CYC(QUIET_CYC)) u_props (
  .core_clk(core_clk), .reset(reset), .line_energy(line_energy), .host_pdown(host_pdown),
  .loopback_mdi(loopback_mdi), .an_full_duplex(an_full_duplex), .mgmt_data_o(mgmt_data_o),
  .mgmt_data_oe(mgmt_data_oe), .plugged_state_flag(plugged_state_flag),
  .reduced_power(reduced_power), .line_off(line_off), .host_link_slow(host_link_slow),
  .loopback_en(loopback_en), .rx_dead(rx_dead), .an_enable(an_enable),
  .an_restart(an_restart), .speed_100(speed_100), .full_duplex(full_duplex));
